/* File: core/ptpce_top.sv */
// Precision time clock with target compare, event pins and APB registers
`timescale 1ns/100ps
module ptpce_top #(
    parameter int NPIN  = 2,
    parameter int NSTMP = 6
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Time stamp unit events, one-cycle pulses
    input  wire logic [NSTMP-1:0] stamp_evt,
    // Event pins
    input  wire logic [NPIN-1:0]  ev_pin_level,
    output logic      [NPIN-1:0]  ev_pin_drive,
    output logic      [NPIN-1:0]  ev_pin_drive_en,
    // System interrupt status contribution
    output logic                  precision_time_event_bit
);
    typedef struct packed {
        logic [63:0]                 time_v;
        logic [31:0]                 acc;
        logic [31:0]                 addend;
        logic [63:0]                 target;
        logic [63:0]                 rearm;
        logic [63:0]                 snap;
        logic [63:0]                 time_stg;
        logic [63:0]                 tgt_stg;
        logic [63:0]                 rearm_stg;
        logic [1:0]                  time_pend;
        logic [1:0]                  tgt_pend;
        logic [1:0]                  rearm_pend;
        logic [ptpce_pkg::CFG_W-1:0] cfg;
        logic [ptpce_pkg::NFLAG-1:0] sts;
        logic [ptpce_pkg::NFLAG-1:0] en;
        logic [1:0][63:0]            cap;
        logic                        eq;
        logic [1:0]                  raw;
        logic [1:0][3:0]             pcnt;
        logic [1:0]                  drv;
        logic [1:0]                  drv_en;
        logic                        rdy;
        logic [31:0]                 rdata;
        logic                        err;
        logic                        evt;
    } ptpce_top_s;

    ptpce_top_s q, d;

    logic [1:0] pin_edge;
    logic       carry;
    logic       match;
    logic       time_load;
    logic       wr;

    // One filter per event pin
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_pin
            ptpce_pin_filt u_filt (
                .pclk        (pclk),
                .presetn     (presetn),
                .pin_level   (ev_pin_level[gi]),
                .active_high (q.cfg[ptpce_pkg::CFG_POL + gi]),
                .edge_evt    (pin_edge[gi])
            );
        end
    endgenerate

    // Read multiplexer; time words read the snapshot, never the live count
    function automatic logic [32:0] read_reg(input ptpce_top_s s, input logic [7:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h0};
        case (a)
            ptpce_pkg::OFS_TIME_HI:  r = {1'b1, s.snap[63:32]};
            ptpce_pkg::OFS_TIME_LO:  r = {1'b1, s.snap[31:0]};
            ptpce_pkg::OFS_ADDEND:   r = {1'b1, s.addend};
            ptpce_pkg::OFS_TGT_HI:   r = {1'b1, s.target[63:32]};
            ptpce_pkg::OFS_TGT_LO:   r = {1'b1, s.target[31:0]};
            ptpce_pkg::OFS_REARM_HI: r = {1'b1, s.rearm[63:32]};
            ptpce_pkg::OFS_REARM_LO: r = {1'b1, s.rearm[31:0]};
            ptpce_pkg::OFS_CMD:      r = {1'b1, 32'h0};
            ptpce_pkg::OFS_CFG:      r = {1'b1, 19'h0, s.cfg};
            ptpce_pkg::OFS_IRQ:      r = {1'b1, 7'h0, s.en, 7'h0, s.sts};
            ptpce_pkg::OFS_CAP0_HI:  r = {1'b1, s.cap[0][63:32]};
            ptpce_pkg::OFS_CAP0_LO:  r = {1'b1, s.cap[0][31:0]};
            ptpce_pkg::OFS_CAP1_HI:  r = {1'b1, s.cap[1][63:32]};
            ptpce_pkg::OFS_CAP1_LO:  r = {1'b1, s.cap[1][31:0]};
            ptpce_pkg::OFS_SYS_IRQ:  r = {1'b1, 31'h0, s.evt};
            default:                 r = {1'b0, 32'h0};
        endcase
        return r;
    endfunction

    // Next state of the whole block
    always_comb
    begin
        logic [32:0]             sum;
        logic [32:0]             rd;
        logic [ptpce_pkg::NFLAG-1:0] set_f;
        logic [ptpce_pkg::NFLAG-1:0] clr_f;
        logic                    pin_clr;
        logic                    in_mode;
        logic [1:0]              mode;
        d = q;
        sum = 33'h0;
        rd = 33'h0;
        set_f = '0;
        clr_f = '0;
        pin_clr = 1'b0;
        in_mode = 1'b0;
        mode = 2'b00;

        // APB: access phase is two cycles, write lands on the ready edge
        wr = psel & penable & pwrite & q.rdy;
        d.rdy = psel & penable & ~q.rdy;
        rd = read_reg(q, paddr);
        if (psel & penable & ~q.rdy)
        begin
            d.rdata = pwrite ? 32'h0 : rd[31:0];
            d.err = ~rd[32];
        end

        // Fractional accumulator; time wraps through zero naturally
        sum = {1'b0, q.acc} + {1'b0, q.addend};
        d.acc = sum[31:0];
        carry = sum[32];
        if (carry)
            d.time_v = q.time_v + 64'h1;

        // Compare on the live values; edge so a resting match fires once
        d.eq = (q.time_v == q.target);
        match = d.eq & ~q.eq;
        if (match)
        begin
            if (q.cfg[ptpce_pkg::CFG_RELOAD])
                d.target = q.rearm;
            else
                d.target = q.target + {32'h0, q.rearm[31:0]};
        end

        // Host register writes; 64-bit registers wait for both halves
        time_load = 1'b0;
        if (wr)
        begin
            case (paddr)
                ptpce_pkg::OFS_TIME_HI, ptpce_pkg::OFS_TIME_LO:
                begin
                    if (paddr == ptpce_pkg::OFS_TIME_HI)
                    begin
                        d.time_stg[63:32] = pwdata;
                        d.time_pend[1] = 1'b1;
                    end
                    else
                    begin
                        d.time_stg[31:0] = pwdata;
                        d.time_pend[0] = 1'b1;
                    end
                    if (&d.time_pend)
                    begin
                        d.time_v = d.time_stg;
                        d.time_pend = 2'b00;
                        time_load = 1'b1;
                    end
                end
                ptpce_pkg::OFS_TGT_HI, ptpce_pkg::OFS_TGT_LO:
                begin
                    if (paddr == ptpce_pkg::OFS_TGT_HI)
                    begin
                        d.tgt_stg[63:32] = pwdata;
                        d.tgt_pend[1] = 1'b1;
                    end
                    else
                    begin
                        d.tgt_stg[31:0] = pwdata;
                        d.tgt_pend[0] = 1'b1;
                    end
                    if (&d.tgt_pend)
                    begin
                        d.target = d.tgt_stg;
                        d.tgt_pend = 2'b00;
                    end
                end
                ptpce_pkg::OFS_REARM_HI, ptpce_pkg::OFS_REARM_LO:
                begin
                    if (paddr == ptpce_pkg::OFS_REARM_HI)
                    begin
                        d.rearm_stg[63:32] = pwdata;
                        d.rearm_pend[1] = 1'b1;
                    end
                    else
                    begin
                        d.rearm_stg[31:0] = pwdata;
                        d.rearm_pend[0] = 1'b1;
                    end
                    if (&d.rearm_pend)
                    begin
                        d.rearm = d.rearm_stg;
                        d.rearm_pend = 2'b00;
                    end
                end
                ptpce_pkg::OFS_ADDEND:
                    d.addend = pwdata;
                ptpce_pkg::OFS_CMD:
                    if (pwdata[ptpce_pkg::CMD_SNAPSHOT])
                        d.snap = q.time_v;
                ptpce_pkg::OFS_CFG:
                    d.cfg = pwdata[ptpce_pkg::CFG_W-1:0];
                ptpce_pkg::OFS_IRQ:
                begin
                    clr_f = pwdata[ptpce_pkg::NFLAG-1:0];
                    d.en = pwdata[ptpce_pkg::IRQ_EN_POS +: ptpce_pkg::NFLAG];
                end
                default:
                    d.snap = q.snap;
            endcase
        end

        // Input pins: capture the time and maybe clear the timer flag
        for (int i = 0; i < 2; i++)
        begin
            in_mode = ~q.cfg[ptpce_pkg::CFG_OE + i];
            if (pin_edge[i] & in_mode)
            begin
                set_f[ptpce_pkg::FLAG_CAP + i] = 1'b1;
                // Locked capture is kept until software clears its flag
                if (!(q.cfg[ptpce_pkg::CFG_LOCK + i] & q.sts[ptpce_pkg::FLAG_CAP + i]))
                    d.cap[i] = q.time_v;
                if (q.cfg[ptpce_pkg::CFG_CLR_EN + i])
                    pin_clr = 1'b1;
            end
        end

        // Sticky flags: a new event wins over any clear in the same cycle
        set_f[NSTMP-1:0] = stamp_evt;
        set_f[ptpce_pkg::FLAG_TIMER] = match;
        if (pin_clr)
            clr_f[ptpce_pkg::FLAG_TIMER] = 1'b1;
        d.sts = (q.sts & ~clr_f) | set_f;
        d.evt = |(q.sts & q.en);

        // Output pins follow target matches in the selected mode
        for (int i = 0; i < 2; i++)
        begin
            mode = q.cfg[ptpce_pkg::CFG_MODE + 2 * i +: 2];
            if (q.pcnt[i] != 4'h0)
                d.pcnt[i] = q.pcnt[i] - 4'h1;
            case (mode)
                ptpce_pkg::PTPCE_PULSE:
                begin
                    if (match)
                        d.pcnt[i] = 4'(ptpce_pkg::PULSE_CYC);
                    d.raw[i] = (d.pcnt[i] != 4'h0);
                end
                ptpce_pkg::PTPCE_TOGGLE:
                    if (match)
                        d.raw[i] = ~q.raw[i];
                default:
                    d.raw[i] = d.sts[ptpce_pkg::FLAG_TIMER];
            endcase
            // Polarity bit high means the event level is high on the pin
            d.drv[i] = q.cfg[ptpce_pkg::CFG_POL + i] ? d.raw[i] : ~d.raw[i];
            d.drv_en[i] = q.cfg[ptpce_pkg::CFG_OE + i];
        end
    end

    // Whole state in one register; reset clears everything to zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= '0;
        else
            q <= d;
    end

    // Outputs straight from the state register
    assign prdata = q.rdata;
    assign pready = q.rdy;
    assign pslverr = q.err;
    assign ev_pin_drive = q.drv;
    assign ev_pin_drive_en = q.drv_en;
    assign precision_time_event_bit = q.evt;

    // Checks
    a_carry_tick: assert property (@(posedge pclk) disable iff (!presetn)
        carry && !time_load |=> q.time_v == $past(q.time_v) + 64'h1)
        else $error("time did not advance on carry");
    a_no_carry_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !carry && !time_load |=> q.time_v == $past(q.time_v))
        else $error("time moved without carry");
    a_match_flag: assert property (@(posedge pclk) disable iff (!presetn)
        match |=> q.sts[ptpce_pkg::FLAG_TIMER])
        else $error("match did not set timer flag");
    a_reload_mode: assert property (@(posedge pclk) disable iff (!presetn)
        match && q.cfg[ptpce_pkg::CFG_RELOAD] && !wr |=> q.target == $past(q.rearm))
        else $error("reload mode target wrong");
    a_add_mode: assert property (@(posedge pclk) disable iff (!presetn)
        match && !q.cfg[ptpce_pkg::CFG_RELOAD] && !wr
        |=> q.target == $past(q.target) + {32'h0, $past(q.rearm[31:0])})
        else $error("add mode target wrong");

    a_half_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == ptpce_pkg::OFS_TIME_LO && q.time_pend == 2'b00
        |=> q.time_pend == 2'b01 && q.time_v != q.time_stg ##0 !time_load)
        else $error("single time half applied");

    a_snapshot: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == ptpce_pkg::OFS_CMD && pwdata[ptpce_pkg::CMD_SNAPSHOT]
        |=> q.snap == $past(q.time_v))
        else $error("snapshot not taken");

    a_event_or: assert property (@(posedge pclk) disable iff (!presetn)
        q.evt == |($past(q.sts) & $past(q.en)))
        else $error("system event bit wrong");

    a_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
        pin_edge[0] && q.cfg[ptpce_pkg::CFG_LOCK] && q.sts[ptpce_pkg::FLAG_CAP]
        |=> $stable(q.cap[0]))
        else $error("locked capture overwritten");

    a_pulse_len: assert property (@(posedge pclk) disable iff (!presetn)
        match && q.cfg[ptpce_pkg::CFG_MODE +: 2] == ptpce_pkg::PTPCE_PULSE
        |=> q.raw[0] [*8])
        else $error("output pulse too short");

    a_pin_clear: assert property (@(posedge pclk) disable iff (!presetn)
        pin_edge[0] && !q.cfg[ptpce_pkg::CFG_OE] && q.cfg[ptpce_pkg::CFG_CLR_EN] && !match
        |=> !q.sts[ptpce_pkg::FLAG_TIMER])
        else $error("pin edge did not clear timer flag");

    c_match: cover property (@(posedge pclk) disable iff (!presetn) match);
    c_capture: cover property (@(posedge pclk) disable iff (!presetn) pin_edge[0] ##1 pin_edge[1]);
    c_time_load: cover property (@(posedge pclk) disable iff (!presetn) time_load);
endmodule // ptpce_top

/* File: pkg/ptpce_pkg.sv */
// Constants, register map and field layout of the precision time clock block
package ptpce_pkg;
    // Clock and pin timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int PULSE_NS      = 100;
    localparam int PULSE_CYC     = PULSE_NS / CLK_PERIOD_NS;
    localparam int GLITCH_NS     = 40;
    // Pin must stay active strictly longer than the glitch time
    localparam int FILT_CYC      = GLITCH_NS / CLK_PERIOD_NS + 1;

    // Register byte offsets
    localparam logic [7:0] OFS_TIME_HI  = 8'h00;
    localparam logic [7:0] OFS_TIME_LO  = 8'h04;
    localparam logic [7:0] OFS_ADDEND   = 8'h08;
    localparam logic [7:0] OFS_TGT_HI   = 8'h0c;
    localparam logic [7:0] OFS_TGT_LO   = 8'h10;
    localparam logic [7:0] OFS_REARM_HI = 8'h14;
    localparam logic [7:0] OFS_REARM_LO = 8'h18;
    localparam logic [7:0] OFS_CMD      = 8'h1c;
    localparam logic [7:0] OFS_CFG      = 8'h20;
    localparam logic [7:0] OFS_IRQ      = 8'h24;
    localparam logic [7:0] OFS_CAP0_HI  = 8'h28;
    localparam logic [7:0] OFS_CAP0_LO  = 8'h2c;
    localparam logic [7:0] OFS_CAP1_HI  = 8'h30;
    localparam logic [7:0] OFS_CAP1_LO  = 8'h34;
    localparam logic [7:0] OFS_SYS_IRQ  = 8'h38;

    // Command and configuration fields
    localparam int CMD_SNAPSHOT  = 0;
    localparam int CFG_RELOAD    = 0;
    localparam int CFG_LOCK      = 1;  // Two bits, one per pin
    localparam int CFG_OE        = 3;  // Two bits
    localparam int CFG_CLR_EN    = 5;  // Two bits
    localparam int CFG_MODE      = 7;  // Two bits per pin, four total
    localparam int CFG_POL       = 11; // Two bits
    localparam int CFG_W         = 13;

    // Status and enable layout: stamps [5:0], pin captures [7:6], timer [8]
    localparam int NFLAG         = 9;
    localparam int FLAG_CAP      = 6;
    localparam int FLAG_TIMER    = 8;
    localparam int IRQ_EN_POS    = 16;

    // Output event modes per pin
    typedef enum logic [1:0] {
        PTPCE_PULSE  = 2'b00,
        PTPCE_TOGGLE = 2'b01,
        PTPCE_FOLLOW = 2'b10
    } ptpce_mode_e;
endpackage

/* File: core/ptpce_pin_filt.sv */
// Event pin synchroniser and pulse width filter
`timescale 1ns/100ps
module ptpce_pin_filt (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Pin and polarity
    input  wire logic pin_level,
    input  wire logic active_high,
    // One-cycle edge event after filtering
    output logic      edge_evt
);
    typedef struct packed {
        logic       s1;
        logic       s2;
        logic [3:0] cnt;
        logic       evt;
    } ptpce_filt_s;

    ptpce_filt_s q, d;

    // Count cycles at the active level, fire once when the width is proven
    always_comb
    begin
        d = q;
        d.s1 = pin_level;
        d.s2 = q.s1;
        d.evt = 1'b0;
        if (q.s2 == active_high)
        begin
            if (q.cnt != 4'(ptpce_pkg::FILT_CYC))
            begin
                d.cnt = q.cnt + 4'h1;
                d.evt = (q.cnt == 4'(ptpce_pkg::FILT_CYC - 1));
            end
        end
        else
        begin
            d.cnt = 4'h0;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= '0;
        else
            q <= d;
    end

    assign edge_evt = q.evt;
endmodule // ptpce_pin_filt

/* File: tb/ptpce_top_tb.sv */
// Self-checking bench for the precision time clock block
`timescale 1ns/100ps
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            n_errors++; \
            $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (got), (exp)); \
        end \
    end
module ptpce_top_tb;
    // Design ports; the inputs are given a value at time zero, the outputs are not
    logic        pclk                     = 1'b0;
    logic        presetn                  = 1'b0;
    logic        psel                     = 1'b0;
    logic        penable                  = 1'b0;
    logic        pwrite                   = 1'b0;
    logic [7:0]  paddr                    = 8'h00;
    logic [31:0] pwdata                   = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  stamp_evt                = 6'h00;
    logic [1:0]  ev_pin_level             = 2'h3;
    logic [1:0]  ev_pin_drive;
    logic [1:0]  ev_pin_drive_en;
    logic        precision_time_event_bit;
    // Bench state and model of time, target and rearm
    logic [31:0] rd;
    logic        err;
    logic [31:0] seed                     = 32'h48;
    logic [63:0] tm_m;
    logic [63:0] tg_m;
    logic [63:0] rl_m;
    logic [63:0] v;
    logic        rel_m                    = 1'b0;
    int          n_errors                 = 0;
    int          check_count              = 0;
    int          cyc                      = 0;
    int          c0;
    int          c1;
    int          n;

    ptpce_top u_ptpce_top (
        .pclk                     (pclk),
        .presetn                  (presetn),
        .psel                     (psel),
        .penable                  (penable),
        .pwrite                   (pwrite),
        .paddr                    (paddr),
        .pwdata                   (pwdata),
        .prdata                   (prdata),
        .pready                   (pready),
        .pslverr                  (pslverr),
        .stamp_evt                (stamp_evt),
        .ev_pin_level             (ev_pin_level),
        .ev_pin_drive             (ev_pin_drive),
        .ev_pin_drive_en          (ev_pin_drive_en),
        .precision_time_event_bit (precision_time_event_bit)
    );

    // 100 MHz clock
    always #(ptpce_pkg::CLK_PERIOD_NS / 2) pclk = ~pclk;

    // Cycle count; a hang is cut short well past the expected run length
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            finish_test();
        end
    end

    // Fixed-seed xorshift source for stimulus values
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // One APB transfer; waits for pready however long it takes
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd  = prdata;
        err = pslverr;
        c0  = cyc;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Idle edge so back-to-back calls never assign psel twice in one step
        @(posedge pclk);
    endtask

    // Write a 64-bit pair, high word first
    task automatic wr64(input logic [7:0] a, input logic [63:0] d);
        apb(1'b1, a, d[63:32]);
        apb(1'b1, a + 8'h04, d[31:0]);
    endtask

    // Read a 64-bit pair and compare with the model
    task automatic chk64(input logic [7:0] a, input logic [63:0] exp);
        logic [31:0] hi;
        apb(1'b0, a, 32'h0);
        hi = rd;
        apb(1'b0, a + 8'h04, 32'h0);
        `CHK({hi, rd}, exp)
    endtask

    // Move time onto the target; in reload mode a fresh rearm keeps targets distinct
    task automatic hit();
        logic [63:0] nxt;
        if (rel_m)
        begin
            rl_m = {xs(), xs()};
            wr64(ptpce_pkg::OFS_REARM_HI, rl_m);
        end
        // Next target comes from the rearm value standing when the match happens
        nxt = rel_m ? rl_m : tg_m + {32'h0, rl_m[31:0]};
        wr64(ptpce_pkg::OFS_TIME_HI, tg_m);
        tm_m = tg_m;
        tg_m = nxt;
    endtask

    // Drive an event pin to its active low level for n cycles
    task automatic pin(input int i, input int cnt);
        ev_pin_level[i] <= 1'b0;
        repeat (cnt) @(posedge pclk);
        ev_pin_level[i] <= 1'b1;
        repeat (12) @(posedge pclk);
    endtask

    // Verdict
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, ptpce_pkg::OFS_CMD, 32'h1);
        chk64(ptpce_pkg::OFS_TIME_HI, 64'h0);
        apb(1'b0, ptpce_pkg::OFS_CFG, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, ptpce_pkg::OFS_ADDEND, 32'h0);
        `CHK(rd, 32'h0)
        // Bit 8 skipped: time and target are both zero out of reset
        apb(1'b0, ptpce_pkg::OFS_IRQ, 32'h0);
        `CHK(rd & 32'h01ff_00ff, 32'h0)
        apb(1'b0, 8'h3c, 32'h0);
        `CHK({err, rd}, 33'h1_0000_0000)
        apb(1'b1, ptpce_pkg::OFS_IRQ, 32'h1ff);
        // Halves apply only as a pair, low word first here; snapshot holds
        v = {xs(), xs()};
        apb(1'b1, ptpce_pkg::OFS_TIME_LO, v[31:0]);
        apb(1'b1, ptpce_pkg::OFS_CMD, 32'h1);
        chk64(ptpce_pkg::OFS_TIME_HI, 64'h0);
        apb(1'b1, ptpce_pkg::OFS_TIME_HI, v[63:32]);
        apb(1'b1, ptpce_pkg::OFS_CMD, 32'h1);
        wr64(ptpce_pkg::OFS_TIME_HI, ~v);
        chk64(ptpce_pkg::OFS_TIME_HI, v);
        apb(1'b1, ptpce_pkg::OFS_CMD, 32'h1);
        chk64(ptpce_pkg::OFS_TIME_HI, ~v);
        // Run the clock across the 64-bit wrap and into a target in add mode
        // Low word kept large so the running clock cannot reach the re-armed target
        rl_m = {xs(), xs() | 32'h0000_0100};
        wr64(ptpce_pkg::OFS_REARM_HI, rl_m);
        tg_m = 64'h1;
        wr64(ptpce_pkg::OFS_TGT_HI, tg_m);
        tm_m = 64'hffff_ffff_ffff_fffd;
        wr64(ptpce_pkg::OFS_TIME_HI, tm_m);
        apb(1'b1, ptpce_pkg::OFS_ADDEND, 32'h4000_0000);
        c1 = c0;
        repeat (20) @(posedge pclk);
        apb(1'b1, ptpce_pkg::OFS_ADDEND, 32'h0);
        v    = 64'(c0 - c1) * 64'h4000_0000;
        tm_m = tm_m + (v >> 32);
        tg_m = tg_m + {32'h0, rl_m[31:0]};
        apb(1'b1, ptpce_pkg::OFS_CMD, 32'h1);
        chk64(ptpce_pkg::OFS_TIME_HI, tm_m);
        apb(1'b0, ptpce_pkg::OFS_IRQ, 32'h0);
        `CHK(rd[8:0], 9'h100)
        apb(1'b1, ptpce_pkg::OFS_IRQ, 32'h1ff);
        // Stamp flags and the masked OR into the system event bit
        v = {32'h0, xs() | 32'h1};
        stamp_evt <= v[5:0];
        @(posedge pclk);
        stamp_evt <= 6'h00;
        @(posedge pclk);
        apb(1'b0, ptpce_pkg::OFS_IRQ, 32'h0);
        `CHK(rd[8:0], {3'b000, v[5:0]})
        apb(1'b1, ptpce_pkg::OFS_IRQ, {10'h0, ~v[5:0], 16'h0});
        @(posedge pclk);
        `CHK(precision_time_event_bit, 1'b0)
        apb(1'b1, ptpce_pkg::OFS_IRQ, {10'h0, v[5:0], 16'h0});
        @(posedge pclk);
        `CHK(precision_time_event_bit, 1'b1)
        apb(1'b0, ptpce_pkg::OFS_SYS_IRQ, 32'h0);
        `CHK(rd, 32'h1)
        apb(1'b1, ptpce_pkg::OFS_IRQ, 32'h1ff);
        @(posedge pclk);
        `CHK(precision_time_event_bit, 1'b0)
        // Pin inputs: short pulse ignored, long pulse captures and clears
        apb(1'b1, ptpce_pkg::OFS_CFG, 32'h20);
        hit();
        pin(1, 4);
        apb(1'b0, ptpce_pkg::OFS_IRQ, 32'h0);
        `CHK(rd[8:0], 9'h100)
        pin(0, 6);
        apb(1'b0, ptpce_pkg::OFS_IRQ, 32'h0);
        `CHK(rd[8:0], 9'h040)
        chk64(ptpce_pkg::OFS_CAP0_HI, tm_m);
        // Capture lock keeps the old value while the flag stands
        apb(1'b1, ptpce_pkg::OFS_CFG, 32'h22);
        v    = tm_m;
        tm_m = tm_m + 64'h5;
        wr64(ptpce_pkg::OFS_TIME_HI, tm_m);
        pin(0, 6);
        chk64(ptpce_pkg::OFS_CAP0_HI, v);
        apb(1'b1, ptpce_pkg::OFS_IRQ, 32'h40);
        pin(0, 6);
        chk64(ptpce_pkg::OFS_CAP0_HI, tm_m);
        pin(1, 6);
        chk64(ptpce_pkg::OFS_CAP1_HI, tm_m);
        // Pin 1 as output, reload mode: pulse, toggle, follow, polarity
        apb(1'b1, ptpce_pkg::OFS_CFG, 32'h1011);
        rel_m = 1'b1;
        hit();
        n = 0;
        repeat (25)
        begin
            @(posedge pclk);
            n = n + int'(ev_pin_drive[1] === 1'b1);
        end
        `CHK(n, ptpce_pkg::PULSE_CYC)
        `CHK(ev_pin_drive_en, 2'b10)
        apb(1'b1, ptpce_pkg::OFS_CFG, 32'h1211);
        v[0] = ev_pin_drive[1];
        hit();
        repeat (3) @(posedge pclk);
        `CHK(ev_pin_drive[1], ~v[0])
        apb(1'b1, ptpce_pkg::OFS_CFG, 32'h1411);
        apb(1'b1, ptpce_pkg::OFS_IRQ, 32'h100);
        repeat (3) @(posedge pclk);
        `CHK(ev_pin_drive[1], 1'b0)
        hit();
        repeat (3) @(posedge pclk);
        `CHK(ev_pin_drive[1], 1'b1)
        apb(1'b1, ptpce_pkg::OFS_CFG, 32'h0411);
        repeat (3) @(posedge pclk);
        `CHK(ev_pin_drive[1], 1'b0)
        finish_test();
    end
endmodule // ptpce_top_tb
